/* File: logic/ebha_arbiter.sv */
`timescale 1ns/1ps
`default_nettype none
module ebha_arbiter (
    // Clocking
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic clkEn,
    // Hold handshake and bus pin control
    input wire logic busRequestN,
    output logic busGrantN,
    output logic busDriveEn,
    output logic prechargeAll,
    // Pin modes and power state
    input wire logic portPinACtrl,
    input wire logic portPinBCtrl,
    input wire logic haltMode,
    input wire logic stopIdleMode,
    // Bus configuration
    input wire logic bus8Bit,
    input wire logic ctrlWrite,
    input wire logic [ebha_pkg::CTRL_W-1:0] ctrlData,
    output logic [ebha_pkg::CTRL_W-1:0] busCycleCtrl,
    // Requesters
    input wire logic refreshReq,
    input wire ebha_pkg::ebha_req_s dmaReq,
    input wire ebha_pkg::ebha_req_s opReq,
    input wire ebha_pkg::ebha_fetch_s fetchReq,
    // Answers and bus cycle
    output logic refreshAck,
    output logic dmaAck,
    output logic opDone,
    output logic fetchDone,
    output logic fetchUndef,
    output logic cpuStall,
    output ebha_pkg::ebha_cycle_s cycle
);
    import ebha_pkg::*;

    typedef enum logic [2:0] {ST_FREE, ST_ADDR, ST_DATA, ST_IDLE, ST_PRECH, ST_HOLD} ebha_state_e;

    ebha_state_e state_q;
    logic reqSyncN;
    logic holdWant;
    logic holdBlocked;
    logic goHold;
    logic serveInt;
    logic startExt;
    logic opServed;
    logic opLast;
    ebha_kind_e choice;
    ebha_req_s op_q;
    logic opActive_q;
    logic opWrPhase_q;
    logic rmwGap_q;
    logic [2:0] pieceIdx_q;
    logic lastPiece_q;
    logic [IDLE_W-1:0] idleCnt_q;
    logic [IDLE_W-1:0] idleSel;
    ebha_piece_s piece;
    ebha_addr_t pieceAddr;
    ebha_region_e opRegion;
    ebha_region_e fetchRegion;

    // Breaks an operand into bus-width pieces
    function automatic ebha_piece_s pieceOf(ebha_size_e sz, logic [1:0] lo, logic b8, logic [2:0] idx);
        ebha_piece_s p;
        p = '{cnt: 3'h1, size: sz, off: 2'h0};
        if (b8) begin
            p.size = SZ_BYTE;
            p.off = idx[1:0];
            unique case (sz)
                SZ_BYTE: p.cnt = 3'h1;
                SZ_HALF: p.cnt = 3'h2;
                default: p.cnt = 3'h4;
            endcase
        end else if (sz == SZ_HALF && lo[0]) begin
            p.cnt = 3'h2;
            p.size = SZ_BYTE;
            p.off = idx[1:0];
        end else if (sz == SZ_WORD && lo[0]) begin
            p.cnt = 3'h3;
            p.size = (idx == 3'h1) ? SZ_HALF : SZ_BYTE;
            p.off = (idx == 3'h0) ? 2'h0 : ((idx == 3'h1) ? 2'h1 : 2'h3);
        end else if (sz == SZ_WORD) begin
            // Aligned words also need two cycles on a halfword bus
            p.cnt = 3'h2;
            p.size = SZ_HALF;
            p.off = {idx[0], 1'b0};
        end
        return p;
    endfunction

    ebha_sync #(
        .RESET_VAL(REQ_INACTIVE)
    ) u_reqSync (
        .sys_clk(sys_clk),
        .srst(srst),
        .clkEn(clkEn),
        .asyncIn(busRequestN),
        .syncOut(reqSyncN)
    );

    assign piece = pieceOf(op_q.size, op_q.addr[1:0], bus8Bit, pieceIdx_q);
    assign pieceAddr = op_q.addr + ebha_addr_t'(piece.off);
    assign opRegion = regionOf(pieceAddr);
    assign fetchRegion = regionOf(fetchReq.addr);
    assign idleSel = busCycleCtrl[cycle.cs*IDLE_W +: IDLE_W];
    assign opLast = (pieceIdx_q + 3'h1 == piece.cnt) && (opWrPhase_q || !op_q.rmw);

    always_comb begin
        holdWant = !reqSyncN && portPinACtrl && portPinBCtrl;
        if (stopIdleMode) begin
            holdWant = 1'b0;
        end
    end

    // Mid-sequence of a locked split or a bit read-modify-write
    assign holdBlocked = opActive_q && (op_q.lock || op_q.rmw) &&
        (pieceIdx_q != 3'h0 || opWrPhase_q);

    // Halt leaves nothing in flight, so the grant path opens at once
    assign goHold = (state_q == ST_FREE) && holdWant && (haltMode || !holdBlocked);

    always_comb begin
        choice = CYC_NONE;
        if (refreshReq) begin
            choice = CYC_REFRESH;
        end else if (dmaReq.valid) begin
            choice = CYC_DMA;
        end else if (opActive_q && !(rmwGap_q && fetchReq.valid && !fetchDone)) begin
            choice = CYC_OPERAND;
        end else if (fetchReq.valid && !fetchDone) begin
            choice = CYC_FETCH;
        end
    end

    always_comb begin
        serveInt = 1'b0;
        if (state_q == ST_FREE && !goHold) begin
            serveInt = (choice == CYC_OPERAND && opRegion != RG_EXT) ||
                (choice == CYC_FETCH && fetchRegion != RG_EXT);
        end else if (state_q == ST_HOLD) begin
            // Only internal RAM and undefined fetches run while held
            serveInt = (choice == CYC_OPERAND && opRegion == RG_IRAM) ||
                (choice == CYC_FETCH && fetchRegion != RG_EXT);
        end
    end

    assign startExt = (state_q == ST_FREE) && !goHold && !serveInt && choice != CYC_NONE;
    assign opServed = (serveInt || startExt) && choice == CYC_OPERAND;

    // Bus state, pin drive and grant
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state_q <= ST_FREE;
            busGrantN <= 1'b1;
            busDriveEn <= 1'b1;
            prechargeAll <= 1'b0;
            idleCnt_q <= '0;
        end else if (clkEn) begin
            prechargeAll <= 1'b0;
            unique case (state_q)
                ST_FREE: begin
                    if (goHold) begin
                        state_q <= ST_PRECH;
                        prechargeAll <= 1'b1;
                    end else if (startExt) begin
                        state_q <= ST_ADDR;
                    end
                end
                ST_ADDR: begin
                    state_q <= ST_DATA;
                end
                ST_DATA: begin
                    if (cycle.kind != CYC_REFRESH && idleSel != '0) begin
                        state_q <= ST_IDLE;
                        idleCnt_q <= idleSel - 1'b1;
                    end else begin
                        state_q <= ST_FREE;
                    end
                end
                ST_IDLE: begin
                    if (idleCnt_q == '0) begin
                        state_q <= ST_FREE;
                    end else begin
                        idleCnt_q <= idleCnt_q - 1'b1;
                    end
                end
                ST_PRECH: begin
                    // Sync stages plus this state keep the grant late enough
                    if (holdWant) begin
                        state_q <= ST_HOLD;
                        busDriveEn <= 1'b0;
                        busGrantN <= 1'b0;
                    end else begin
                        state_q <= ST_FREE;
                    end
                end
                ST_HOLD: begin
                    if (!holdWant) begin
                        state_q <= ST_FREE;
                        busDriveEn <= 1'b1;
                        busGrantN <= 1'b1;
                    end
                end
            endcase
        end
    end

    // External cycle presented to the memory controllers
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cycle <= '0;
            refreshAck <= 1'b0;
            dmaAck <= 1'b0;
        end else if (clkEn) begin
            refreshAck <= 1'b0;
            dmaAck <= 1'b0;
            if (startExt) begin
                cycle.active <= 1'b1;
                cycle.kind <= choice;
                unique case (choice)
                    CYC_REFRESH: begin
                        refreshAck <= 1'b1;
                        cycle.addr <= '0;
                        cycle.size <= SZ_HALF;
                        cycle.write <= 1'b0;
                        cycle.cs <= '0;
                    end
                    CYC_DMA: begin
                        dmaAck <= 1'b1;
                        cycle.addr <= dmaReq.addr;
                        cycle.size <= dmaReq.size;
                        cycle.write <= dmaReq.write;
                        cycle.cs <= dmaReq.cs;
                    end
                    CYC_OPERAND: begin
                        cycle.addr <= pieceAddr;
                        cycle.size <= piece.size;
                        cycle.write <= op_q.write || opWrPhase_q;
                        cycle.cs <= op_q.cs;
                    end
                    default: begin
                        cycle.addr <= fetchReq.addr;
                        cycle.size <= SZ_HALF;
                        cycle.write <= 1'b0;
                        cycle.cs <= fetchReq.cs;
                    end
                endcase
            end else if (state_q == ST_DATA) begin
                cycle.active <= 1'b0;
                cycle.kind <= CYC_NONE;
            end
        end
    end

    // Operand sequencing through its pieces
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            op_q <= '0;
            opActive_q <= 1'b0;
            opWrPhase_q <= 1'b0;
            rmwGap_q <= 1'b0;
            pieceIdx_q <= '0;
            lastPiece_q <= 1'b0;
        end else if (clkEn) begin
            if (!opActive_q && opReq.valid && !opDone) begin
                op_q <= opReq;
                opActive_q <= 1'b1;
                opWrPhase_q <= 1'b0;
                pieceIdx_q <= '0;
            end else if (opServed) begin
                rmwGap_q <= 1'b0;
                lastPiece_q <= opLast;
                if (opLast) begin
                    // External last piece stays active to its data state; no second capture
                    opActive_q <= !serveInt;
                end else if (pieceIdx_q + 3'h1 == piece.cnt) begin
                    // Read half done; write half replays the same pieces
                    opWrPhase_q <= 1'b1;
                    rmwGap_q <= 1'b1;
                    pieceIdx_q <= '0;
                end else begin
                    pieceIdx_q <= pieceIdx_q + 3'h1;
                end
            end else if (state_q == ST_DATA && cycle.kind == CYC_OPERAND && lastPiece_q) begin
                opActive_q <= 1'b0;
            end
        end
    end

    // Completion pulses and stall view
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            opDone <= 1'b0;
            fetchDone <= 1'b0;
            fetchUndef <= 1'b0;
            cpuStall <= 1'b0;
        end else if (clkEn) begin
            opDone <= 1'b0;
            fetchDone <= 1'b0;
            fetchUndef <= 1'b0;
            if (serveInt && choice == CYC_OPERAND) begin
                opDone <= opLast;
            end else if (serveInt && choice == CYC_FETCH) begin
                fetchDone <= 1'b1;
                // Fetches into I/O never reach the pins
                fetchUndef <= (fetchRegion == RG_IO);
            end else if (state_q == ST_DATA && cycle.kind == CYC_OPERAND) begin
                opDone <= lastPiece_q;
            end else if (state_q == ST_DATA && cycle.kind == CYC_FETCH) begin
                fetchDone <= 1'b1;
            end
            cpuStall <= (state_q == ST_HOLD) && !serveInt &&
                ((opActive_q && opRegion != RG_IRAM) || (fetchReq.valid && fetchRegion == RG_EXT));
        end
    end

    // Idle control: software programs it once; no write-once lock here
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            busCycleCtrl <= IDLE_CTRL_RESET;
        end else if (clkEn && ctrlWrite) begin
            busCycleCtrl <= ctrlData;
        end
    end

endmodule
`default_nettype wire

/* File: logic/ebha_pkg.sv */
`default_nettype none
package ebha_pkg;

    localparam int ADDR_W = 26;
    localparam int CS_W = 3;
    localparam int CS_COUNT = 8;
    localparam int IDLE_W = 2;
    localparam int CTRL_W = 16;
    localparam int SYNC_STAGES = 2;
    localparam int GRANT_MIN_CLK = 2;

    typedef logic [ADDR_W-1:0] ebha_addr_t;

    // Top of the map: 4 KB peripheral I/O, 12 KB internal RAM below it
    localparam ebha_addr_t IO_BASE = 26'h3FFF000;
    localparam ebha_addr_t IRAM_BASE = 26'h3FFC000;

    // Two idle-count bits per chip-select space, all set after reset
    localparam logic [CTRL_W-1:0] IDLE_CTRL_RESET = 16'hFFFF;
    localparam logic REQ_INACTIVE = 1'b1;

    typedef enum logic [1:0] {SZ_BYTE, SZ_HALF, SZ_WORD} ebha_size_e;
    typedef enum logic [1:0] {RG_EXT, RG_IRAM, RG_IO} ebha_region_e;
    typedef enum logic [2:0] {CYC_NONE, CYC_REFRESH, CYC_DMA, CYC_OPERAND, CYC_FETCH} ebha_kind_e;

    typedef struct packed {
        logic valid;
        ebha_addr_t addr;
        ebha_size_e size;
        logic write;
        logic rmw;
        logic lock;
        logic [CS_W-1:0] cs;
    } ebha_req_s;

    typedef struct packed {
        logic valid;
        ebha_addr_t addr;
        logic spec;
        logic [CS_W-1:0] cs;
    } ebha_fetch_s;

    typedef struct packed {
        logic active;
        ebha_kind_e kind;
        ebha_addr_t addr;
        ebha_size_e size;
        logic write;
        logic [CS_W-1:0] cs;
    } ebha_cycle_s;

    typedef struct packed {
        logic [2:0] cnt;
        ebha_size_e size;
        logic [1:0] off;
    } ebha_piece_s;

    function automatic ebha_region_e regionOf(ebha_addr_t a);
        ebha_region_e r;
        r = RG_EXT;
        if (a >= IO_BASE) begin
            r = RG_IO;
        end else if (a >= IRAM_BASE) begin
            r = RG_IRAM;
        end
        return r;
    endfunction

endpackage
`default_nettype wire

/* File: logic/ebha_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module ebha_sync #(
    parameter logic RESET_VAL = 1'b1
) (
    // Clocking
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic clkEn,
    // Level crossing
    input wire logic asyncIn,
    output logic syncOut
);
    logic meta_q;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            meta_q <= RESET_VAL;
            syncOut <= RESET_VAL;
        end else if (clkEn) begin
            meta_q <= asyncIn;
            syncOut <= meta_q;
        end
    end
endmodule
`default_nettype wire

/* File: testbench/ebha_arbiter_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module ebha_arbiter_monitor (
    // Clocking
    input wire logic sys_clk,
    input wire logic srst,
    // Hold handshake
    input wire logic busRequestN,
    input wire logic busGrantN,
    input wire logic busDriveEn,
    input wire logic prechargeAll,
    // Modes
    input wire logic portPinACtrl,
    input wire logic portPinBCtrl,
    input wire logic stopIdleMode,
    // Answers
    input wire logic fetchDone,
    input wire logic fetchUndef,
    input wire ebha_pkg::ebha_cycle_s cycle
);
    import ebha_pkg::*;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (srst);
    sequence s_free;
        busGrantN && busDriveEn;
    endsequence
    sequence s_wait3;
        busGrantN [*3];
    endsequence
    a_grant_floats_bus: assert property (busGrantN == busDriveEn)
        else $error("grant and pin float disagree");
    a_release_drives: assert property ($rose(busRequestN) && !busGrantN |-> ##[1:3] s_free)
        else $error("bus not driven again after release");
    a_grant_min_delay: assert property ($fell(busRequestN) && busGrantN |-> s_wait3)
        else $error("grant came too early");
    a_precharge_first: assert property ($fell(busGrantN) |-> $past(prechargeAll))
        else $error("hold entered without precharge");
    a_precharge_pulse: assert property (prechargeAll |=> !prechargeAll)
        else $error("precharge longer than one cycle");
    a_ctrl_off_free: assert property (!(portPinACtrl && portPinBCtrl) |=> s_free)
        else $error("hold with pins not in control mode");
    a_stop_no_hold: assert property (stopIdleMode |=> s_free)
        else $error("hold in stop or idle mode");
    a_held_no_cycle: assert property (!busGrantN |-> !cycle.active)
        else $error("bus cycle while held");
    a_undef_no_bus: assert property (fetchUndef |-> fetchDone && !cycle.active)
        else $error("undefined fetch used the bus");
endmodule
`default_nettype wire

/* File: testbench/ebha_bus_master.sv */
`timescale 1ns/1ps
`default_nettype none
module ebha_bus_master (
    // Clocking
    input wire logic sys_clk,
    // Hold handshake
    output logic busRequestN,
    input wire logic busGrantN
);
    int latency;
    initial busRequestN = 1'b1;
    task automatic req_on();
        @(posedge sys_clk);
        #1 busRequestN = 1'b0;
    endtask
    // Own precharge assumed done before the bus goes back
    task automatic req_off();
        @(posedge sys_clk);
        #1 busRequestN = 1'b1;
    endtask
    // Request, hold for holdLen cycles, then release
    task automatic hold(input int holdLen, output logic granted);
        int n;
        req_on();
        n = 0;
        while (busGrantN !== 1'b0 && n < 12) begin
            @(posedge sys_clk);
            #1 n++;
        end
        latency = n;
        granted = (busGrantN === 1'b0);
        repeat (holdLen) @(posedge sys_clk);
        req_off();
        n = 0;
        while (busGrantN !== 1'b1 && n < 8) begin
            @(posedge sys_clk);
            #1 n++;
        end
        // Let the released level clear the sync stages before modes change
        repeat (2) @(posedge sys_clk);
        #1;
    endtask
endmodule
`default_nettype wire

/* File: testbench/external_bus_hold_arbiter_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module external_bus_hold_arbiter_tb;
    import ebha_pkg::*;
    logic sys_clk, srst, clkEn, busRequestN, busGrantN, busDriveEn, prechargeAll;
    logic portPinACtrl, portPinBCtrl, haltMode, stopIdleMode, bus8Bit, ctrlWrite;
    logic [CTRL_W-1:0] ctrlData, busCycleCtrl;
    logic refreshReq, refreshAck, dmaAck, opDone, fetchDone, fetchUndef, cpuStall, undef;
    ebha_req_s dmaReq, opReq;
    ebha_fetch_s fetchReq;
    ebha_cycle_s cycle;
    int nFail = 0;
    int nCompared = 0;
    int nTick = 0;
    ebha_kind_e kinds[$];
    ebha_addr_t addrs[$];
    ebha_size_e sizes[$];

    ebha_arbiter dut (
        .sys_clk, .srst, .clkEn, .busRequestN, .busGrantN, .busDriveEn, .prechargeAll,
        .portPinACtrl, .portPinBCtrl, .haltMode, .stopIdleMode, .bus8Bit, .ctrlWrite,
        .ctrlData, .busCycleCtrl, .refreshReq, .dmaReq, .opReq, .fetchReq, .refreshAck,
        .dmaAck, .opDone, .fetchDone, .fetchUndef, .cpuStall, .cycle
    );
    ebha_bus_master master (.sys_clk, .busRequestN, .busGrantN);

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    // Cut a hang short
    always @(posedge sys_clk) begin
        nTick <= nTick + 1;
        if (nTick == 5000) begin
            nFail++;
            stopTest();
        end
    end

    task automatic tick();
        @(posedge sys_clk);
        #1;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        nCompared++;
        if (got !== exp) begin
            nFail++;
            $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
        end
    endtask
    task automatic waitGrant(input logic v);
        for (int n = 0; n < 12 && busGrantN !== v; n++) tick();
    endtask
    task automatic stopTest();
        $display("compared %0d, mismatches %0d", nCompared, nFail);
        if (nFail == 0 && nCompared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Step until every request retires, logging each new bus cycle
    task automatic runBus(input int lim);
        ebha_cycle_s prev;
        int n;
        prev = '0;
        n = 0;
        kinds.delete();
        addrs.delete();
        sizes.delete();
        while ((refreshReq || dmaReq.valid || opReq.valid || fetchReq.valid) && n < lim) begin
            tick();
            n++;
            if (cycle.active && cycle != prev) begin
                kinds.push_back(cycle.kind);
                addrs.push_back(cycle.addr);
                sizes.push_back(cycle.size);
            end
            prev = cycle;
            if (refreshAck) refreshReq = 1'b0;
            if (dmaAck) dmaReq.valid = 1'b0;
            if (opDone) opReq.valid = 1'b0;
            if (fetchDone) begin
                fetchReq.valid = 1'b0;
                undef = fetchUndef;
            end
        end
        chk("requests retired", 1, 32'(n < lim));
    endtask

    // Locked or rmw cases get a hold request in mid-sequence
    task automatic opCase(input ebha_addr_t a, input ebha_size_e s, input logic lk, input logic rw,
                          input int en, input ebha_addr_t ea[4], input ebha_size_e es[4]);
        opReq = '{1'b1, a, s, 1'b0, rw, lk, 3'h0};
        fork
            runBus(80);
            if (lk || rw) begin
                // Synced request lands between the first two pieces
                master.req_on();
            end
        join
        chk("piece count", en, kinds.size());
        for (int i = 0; i < en; i++) begin
            chk("piece addr", 32'(ea[i]), 32'(addrs[i]));
            chk("piece size", 32'(es[i]), 32'(sizes[i]));
        end
        if (lk || rw) begin
            waitGrant(1'b0);
            chk("grant after sequence", 0, busGrantN);
            master.req_off();
            waitGrant(1'b1);
        end
    endtask

    task automatic testSplit();
        ctrlWrite = 1'b1;
        ctrlData = 16'h3C3C;
        tick();
        ctrlWrite = 1'b0;
        chk("idle control", 16'h3C3C, busCycleCtrl);
        opCase(26'h101, SZ_HALF, 0, 0, 2, '{26'h101, 26'h102, 26'h0, 26'h0},
            '{SZ_BYTE, SZ_BYTE, SZ_BYTE, SZ_BYTE});
        opCase(26'h101, SZ_WORD, 0, 0, 3, '{26'h101, 26'h102, 26'h104, 26'h0},
            '{SZ_BYTE, SZ_HALF, SZ_BYTE, SZ_BYTE});
        opCase(26'h102, SZ_WORD, 0, 0, 2, '{26'h102, 26'h104, 26'h0, 26'h0},
            '{SZ_HALF, SZ_HALF, SZ_BYTE, SZ_BYTE});
        opCase(26'h100, SZ_HALF, 0, 1, 2, '{26'h100, 26'h100, 26'h0, 26'h0},
            '{SZ_HALF, SZ_HALF, SZ_BYTE, SZ_BYTE});
        bus8Bit = 1'b1;
        opCase(26'h100, SZ_WORD, 1, 0, 4, '{26'h100, 26'h101, 26'h102, 26'h103},
            '{SZ_BYTE, SZ_BYTE, SZ_BYTE, SZ_BYTE});
        bus8Bit = 1'b0;
        $display("split test done");
    endtask

    task automatic testHold();
        logic g;
        master.hold(4, g);
        chk("grant", 1, 32'(g));
        chk("grant latency", 4, master.latency);
        chk("driving again", 1, 32'(busGrantN & busDriveEn));
        portPinACtrl = 1'b0;
        master.hold(2, g);
        chk("grant with pin off", 0, 32'(g));
        portPinACtrl = 1'b1;
        stopIdleMode = 1'b1;
        master.hold(2, g);
        chk("grant in stop", 0, 32'(g));
        stopIdleMode = 1'b0;
        haltMode = 1'b1;
        master.hold(2, g);
        chk("grant in halt", 1, 32'(g));
        haltMode = 1'b0;
        $display("hold test done");
    endtask

    task automatic testPrio();
        ebha_kind_e ek[4] = '{CYC_REFRESH, CYC_DMA, CYC_OPERAND, CYC_FETCH};
        refreshReq = 1'b1;
        dmaReq = '{1'b1, 26'h200, SZ_HALF, 1'b1, 1'b0, 1'b0, 3'h1};
        opReq = '{1'b1, 26'h300, SZ_HALF, 1'b0, 1'b0, 1'b0, 3'h0};
        fetchReq = '{1'b1, 26'h400, 1'b0, 3'h0};
        runBus(100);
        for (int i = 0; i < 4; i++) begin
            chk("cycle kind", 32'(ek[i]), 32'(kinds[i]));
        end
        opReq = '{1'b1, IRAM_BASE, SZ_HALF, 1'b0, 1'b0, 1'b0, 3'h0};
        fetchReq = '{1'b1, IO_BASE, 1'b0, 3'h0};
        runBus(20);
        chk("internal bus cycles", 0, kinds.size());
        chk("undefined fetch", 1, 32'(undef));
        $display("priority test done");
    endtask

    task automatic testResetHold();
        int n;
        srst = 1'b1;
        master.req_on();
        repeat (3) tick();
        srst = 1'b0;
        chk("idle control after reset", 16'hFFFF, busCycleCtrl);
        for (n = 0; n < 12 && busGrantN !== 1'b0; n++) tick();
        chk("grant after reset", 4, n);
        opReq = '{1'b1, 26'h300, SZ_HALF, 1'b0, 1'b0, 1'b0, 3'h0};
        repeat (2) tick();
        chk("stall while held", 1, 32'(cpuStall));
        master.req_off();
        runBus(20);
        $display("reset hold test done");
    endtask

    initial begin
        srst = 1'b1;
        clkEn = 1'b1;
        portPinACtrl = 1'b1;
        portPinBCtrl = 1'b1;
        haltMode = 1'b0;
        stopIdleMode = 1'b0;
        bus8Bit = 1'b0;
        ctrlWrite = 1'b0;
        ctrlData = 16'h0000;
        refreshReq = 1'b0;
        dmaReq = '0;
        opReq = '0;
        fetchReq = '0;
        undef = 1'b0;
        repeat (10) tick();
        srst = 1'b0;
        tick();
        chk("idle control reset", 16'hFFFF, busCycleCtrl);
        testHold();
        testSplit();
        testPrio();
        testResetHold();
        stopTest();
    end
endmodule
bind ebha_arbiter ebha_arbiter_monitor mon (
    .sys_clk, .srst, .busRequestN, .busGrantN, .busDriveEn, .prechargeAll, .portPinACtrl,
    .portPinBCtrl, .stopIdleMode, .fetchDone, .fetchUndef, .cycle
);
`default_nettype wire
